// ==== core/operand_addr_pkg.sv ====
// shared types and constants of the operand address generator
package operand_addr_pkg;

    // ------------------------------------------------------------
    // widths and fixed values
    // ------------------------------------------------------------
    localparam int DATA_W = 8;              // byte width of the core
    localparam int ADDR_W = 16;             // unified memory space width
    localparam logic [7:0] DP_PAGE_HIGH = 8'h00;  // direct page = page 0
    localparam logic [7:0] PTR_STEP = 8'h01;      // pair high byte offset
    localparam logic [7:0] X_INC_STEP = 8'h01;    // auto increment step
    localparam logic [7:0] ZERO_INDEX = 8'h00;    // no index added
    localparam logic [7:0] BYTE_ZERO = 8'h00;     // cleared byte
    localparam logic [15:0] ADDR_ZERO = 16'h0000; // cleared address
    localparam logic [6:0] CARRY_PAD = 7'h00;     // upper bits of carry

    // ------------------------------------------------------------
    // addressing modes, grouped into the six classes
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        MODE_REG      = 4'h0,  // register
        MODE_IMM      = 4'h1,  // immediate
        MODE_DP       = 4'h2,  // direct page
        MODE_ABS      = 4'h3,  // absolute
        MODE_DP_X     = 4'h4,  // indexed, x no offset
        MODE_DP_X_INC = 4'h5,  // indexed, x auto increment
        MODE_DP_OFF_X = 4'h6,  // indexed, dp plus x
        MODE_DP_OFF_Y = 4'h7,  // indexed, dp plus y
        MODE_ABS_Y    = 4'h8,  // indexed, absolute plus y
        MODE_IND_DP   = 4'h9,  // indirect, jump target from dp pair
        MODE_IND_X    = 4'hA,  // indirect, pair at dp plus x
        MODE_IND_Y    = 4'hB   // indirect, pair at dp, then plus y
    } addr_mode_t;

    // register operand selector
    typedef enum logic [2:0] {
        SEL_ACC   = 3'h0,
        SEL_X     = 3'h1,
        SEL_Y     = 3'h2,
        SEL_CARRY = 3'h3,
        SEL_PSW   = 3'h4
    } reg_sel_t;

    // request from the core's decoder
    typedef struct packed {
        logic       valid;   // one-cycle request strobe
        addr_mode_t mode;    // addressing mode
        logic       rmw;     // read-modify-write operation
        reg_sel_t   reg_sel; // register operand in register mode
        logic [7:0] op_lo;   // second instruction byte
        logic [7:0] op_hi;   // third instruction byte
    } op_req_t;

    // architectural registers as seen at request time
    typedef struct packed {
        logic [7:0] acc;
        logic [7:0] x;
        logic [7:0] y;
        logic       carry;
        logic [7:0] program_status_word;
    } core_regs_t;

    // result handed back to the core
    typedef struct packed {
        logic [15:0] ea;       // effective address
        logic [7:0]  data;     // data value (register or immediate)
        logic        has_addr; // ea is meaningful
        logic        has_data; // data is meaningful, no memory lookup
        logic        is_jump;  // ea is a jump target
        logic        rmw;      // read-modify-write on ea
    } op_result_t;

endpackage

// ==== core/page_index_adder.sv ====
// index plus offset inside the direct page
`timescale 1ns/10ps
`default_nettype none
module page_index_adder (
    input wire logic [7:0] offset,
    input wire logic [7:0] index,
    output logic [15:0] page_addr
);
    import operand_addr_pkg::*;

    // ------------------------------------------------------------
    // 8-bit sum, carry dropped so the page wraps
    // ------------------------------------------------------------
    logic [7:0] low_sum; // wrapped low byte

    // carry out is discarded on purpose: never leave page zero
    assign low_sum = 8'(offset + index);
    assign page_addr = {DP_PAGE_HIGH, low_sum};
endmodule
`default_nettype wire

// ==== core/wide_index_adder.sv ====
// 16-bit base plus 8-bit index across the whole space
`timescale 1ns/10ps
`default_nettype none
module wide_index_adder (
    input wire logic [15:0] base,
    input wire logic [7:0] index,
    output logic [15:0] sum
);
    import operand_addr_pkg::*;

    // ------------------------------------------------------------
    // full carry into the high byte, wraps at the top of memory
    // ------------------------------------------------------------
    assign sum = 16'(base + {BYTE_ZERO, index});
endmodule
`default_nettype wire

// ==== core/operand_address_generator.sv ====
// operand address generation for the 8-bit core
`timescale 1ns/10ps
`default_nettype none
module operand_address_generator (
    input wire logic mclk,
    input wire logic rst,
    input wire operand_addr_pkg::op_req_t req,
    input wire operand_addr_pkg::core_regs_t regs,
    output logic req_ready,
    output logic done,
    output operand_addr_pkg::op_result_t result,
    output logic x_inc_valid,
    output logic [7:0] x_inc_value,
    output logic mem_req,
    output logic [15:0] mem_addr,
    input wire logic [7:0] mem_rdata,
    input wire logic mem_ack
);
    import operand_addr_pkg::*;

    // ------------------------------------------------------------
    // sequencer states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE   = 3'b001, // waiting for a request
        ST_PTR_LO = 3'b010, // fetching pointer low byte
        ST_PTR_HI = 3'b100  // fetching pointer high byte
    } seq_state_t;

    seq_state_t state_reg;     // current state
    seq_state_t state_next;    // next state
    op_result_t result_reg;    // registered result
    op_result_t direct_res;    // result of a single-cycle mode
    logic done_reg;            // one-cycle completion strobe
    logic x_inc_reg;           // one-cycle x update strobe
    logic [7:0] x_new_reg;     // incremented x value
    logic [15:0] ptr_addr_reg; // pointer byte address on the bus
    logic [7:0] ptr_lo_reg;    // captured pointer low byte
    logic [7:0] post_idx_reg;  // index added after the pair fetch
    logic is_jump_reg;         // pair gives a jump target
    logic rmw_reg;             // latched rmw flag
    logic accept;              // request taken this cycle
    logic indirect;            // request needs a pointer fetch
    logic [7:0] dp_index;      // index fed to the page adder
    logic [15:0] dp_sum;       // page-wrapped operand plus index
    logic [15:0] wide_base;    // base fed to the wide adder
    logic [7:0] wide_index;    // index fed to the wide adder
    logic [15:0] wide_sum;     // base plus index over all memory
    logic [7:0] reg_value;     // register operand value
    logic [7:0] ptr_next_lo;   // low byte of the pair's second address

    // ------------------------------------------------------------
    // request acceptance
    // ------------------------------------------------------------
    // new requests only in idle; one in flight at a time keeps the
    // pointer capture simple at the cost of no overlap
    assign req_ready = (state_reg == ST_IDLE);
    assign accept = req.valid && req_ready;

    // modes that must read a byte pair before the address is known
    always_comb begin
        unique case (req.mode)
            MODE_IND_DP, MODE_IND_X, MODE_IND_Y: begin
                indirect = 1'b1;
            end
            default: begin
                indirect = 1'b0; // also covers unused codes
            end
        endcase
    end

    // ------------------------------------------------------------
    // adders
    // ------------------------------------------------------------
    // index for the direct page adder, chosen from the mode
    always_comb begin
        unique case (req.mode)
            MODE_DP_OFF_X, MODE_IND_X: begin
                dp_index = regs.x;
            end
            MODE_DP_OFF_Y: begin
                dp_index = regs.y;
            end
            default: begin
                dp_index = ZERO_INDEX;
            end
        endcase
    end

    page_index_adder u_page_adder (
        .offset(req.op_lo),
        .index(dp_index),
        .page_addr(dp_sum)
    );

    // wide adder: absolute plus y at request time, or the fetched
    // pointer plus the latched post index when the pair completes
    always_comb begin
        if (state_reg == ST_PTR_HI) begin
            wide_base = {mem_rdata, ptr_lo_reg};
            wide_index = post_idx_reg;
        end else begin
            wide_base = {req.op_hi, req.op_lo};
            wide_index = regs.y;
        end
    end

    wide_index_adder u_wide_adder (
        .base(wide_base),
        .index(wide_index),
        .sum(wide_sum)
    );

    // second byte of a pair stays in the direct page
    assign ptr_next_lo = 8'(ptr_addr_reg[7:0] + PTR_STEP);

    // ------------------------------------------------------------
    // register operand select
    // ------------------------------------------------------------
    always_comb begin
        unique case (req.reg_sel)
            SEL_ACC: begin
                reg_value = regs.acc;
            end
            SEL_X: begin
                reg_value = regs.x;
            end
            SEL_Y: begin
                reg_value = regs.y;
            end
            SEL_CARRY: begin
                reg_value = {CARRY_PAD, regs.carry};
            end
            SEL_PSW: begin
                reg_value = regs.program_status_word;
            end
            default: begin
                reg_value = BYTE_ZERO; // illegal selector reads zero
            end
        endcase
    end

    // ------------------------------------------------------------
    // single-cycle result forming
    // ------------------------------------------------------------
    always_comb begin
        direct_res = '0;
        direct_res.rmw = req.rmw;
        unique case (req.mode)
            MODE_REG: begin
                // no memory address formed at all
                direct_res.data = reg_value;
                direct_res.has_data = 1'b1;
            end
            MODE_IMM: begin
                direct_res.data = req.op_lo;
                direct_res.has_data = 1'b1;
            end
            MODE_DP: begin
                direct_res.ea = {DP_PAGE_HIGH, req.op_lo};
                direct_res.has_addr = 1'b1;
            end
            MODE_ABS: begin
                // rmw flag passes through for shift, rotate, inc, dec
                direct_res.ea = {req.op_hi, req.op_lo};
                direct_res.has_addr = 1'b1;
            end
            MODE_DP_X, MODE_DP_X_INC: begin
                direct_res.ea = {DP_PAGE_HIGH, regs.x};
                direct_res.has_addr = 1'b1;
            end
            MODE_DP_OFF_X, MODE_DP_OFF_Y: begin
                direct_res.ea = dp_sum;
                direct_res.has_addr = 1'b1;
            end
            MODE_ABS_Y: begin
                direct_res.ea = wide_sum;
                direct_res.has_addr = 1'b1;
            end
            default: begin
                // indirect modes and unused codes: no address or data valid
                direct_res.ea = ADDR_ZERO;
            end
        endcase
    end

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ST_IDLE: begin
                if (accept && indirect) begin
                    state_next = ST_PTR_LO;
                end
            end
            ST_PTR_LO: begin
                if (mem_ack) begin
                    state_next = ST_PTR_HI;
                end
            end
            ST_PTR_HI: begin
                if (mem_ack) begin
                    state_next = ST_IDLE;
                end
            end
            default: begin
                state_next = ST_IDLE; // recover from an illegal code
            end
        endcase
    end

    // state register
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_reg <= ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // memory request is held for the whole pair fetch
    assign mem_req = (state_reg == ST_PTR_LO) || (state_reg == ST_PTR_HI);
    assign mem_addr = ptr_addr_reg;

    // ------------------------------------------------------------
    // pointer address and fetched bytes
    // ------------------------------------------------------------
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ptr_addr_reg <= ADDR_ZERO;
            ptr_lo_reg <= BYTE_ZERO;
        end else if (accept && indirect) begin
            // pair location: operand, or operand plus x
            ptr_addr_reg <= dp_sum;
        end else if (state_reg == ST_PTR_LO && mem_ack) begin
            // low byte sits at the lower location
            ptr_lo_reg <= mem_rdata;
            ptr_addr_reg <= {DP_PAGE_HIGH, ptr_next_lo};
        end
    end

    // attributes of the indirect request kept across the fetch
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            post_idx_reg <= ZERO_INDEX;
            is_jump_reg <= 1'b0;
            rmw_reg <= 1'b0;
        end else if (accept && indirect) begin
            // y is sampled at request so a later change cannot leak in
            post_idx_reg <= (req.mode == MODE_IND_Y) ? regs.y
                                                     : ZERO_INDEX;
            is_jump_reg <= (req.mode == MODE_IND_DP);
            rmw_reg <= req.rmw;
        end
    end

    // ------------------------------------------------------------
    // result register and completion strobe
    // ------------------------------------------------------------
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            result_reg <= '0;
            done_reg <= 1'b0;
        end else if (accept && !indirect) begin
            result_reg <= direct_res;
            done_reg <= 1'b1;
        end else if (state_reg == ST_PTR_HI && mem_ack) begin
            // pair complete: high byte arrives now, plus post index
            result_reg.ea <= wide_sum;
            result_reg.data <= BYTE_ZERO;
            result_reg.has_addr <= 1'b1;
            result_reg.has_data <= 1'b0;
            result_reg.is_jump <= is_jump_reg;
            result_reg.rmw <= rmw_reg;
            done_reg <= 1'b1;
        end else begin
            done_reg <= 1'b0; // result holds until the next one
        end
    end

    // ------------------------------------------------------------
    // x auto increment
    // ------------------------------------------------------------
    // x is owned by the core; it takes x_inc_value on the strobe,
    // which comes with the same done as the address that used old x
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            x_inc_reg <= 1'b0;
            x_new_reg <= BYTE_ZERO;
        end else if (accept && req.mode == MODE_DP_X_INC) begin
            x_inc_reg <= 1'b1;
            x_new_reg <= 8'(regs.x + X_INC_STEP);
        end else begin
            x_inc_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign done = done_reg;
    assign result = result_reg;
    assign x_inc_valid = x_inc_reg;
    assign x_inc_value = x_new_reg;
endmodule
`default_nettype wire

// ==== bench/oag_sva.sv ====
// port-level checks of the operand address generator
`timescale 1ns/10ps
`default_nettype none
module oag_sva (
    input wire logic mclk,
    input wire logic rst,
    input wire operand_addr_pkg::op_req_t req,
    input wire operand_addr_pkg::core_regs_t regs,
    input wire logic req_ready,
    input wire logic done,
    input wire operand_addr_pkg::op_result_t result,
    input wire logic x_inc_valid,
    input wire logic [7:0] x_inc_value,
    input wire logic mem_req,
    input wire logic [15:0] mem_addr,
    input wire logic [7:0] mem_rdata,
    input wire logic mem_ack
);
    import operand_addr_pkg::*;
    // ----
    // helpers
    // ----
    logic take; // request accepted at this edge
    logic ind; // request needs pointer reads
    assign take = req.valid && req_ready;
    assign ind = req.mode inside {MODE_IND_DP, MODE_IND_X, MODE_IND_Y};
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    // ----
    // request to result
    // ----
    direct_done_a: assert property (take && !ind |=> done)
        else $error("direct request without done");
    imm_data_a: assert property (take && req.mode == MODE_IMM |=>
        result.has_data && result.data == $past(req.op_lo))
        else $error("immediate data wrong");
    abs_addr_a: assert property (take && req.mode == MODE_ABS |=>
        result.ea == {$past(req.op_hi), $past(req.op_lo)}
        && result.rmw == $past(req.rmw))
        else $error("absolute address wrong");
    dp_x_a: assert property (take && req.mode == MODE_DP_X |=>
        result.ea == {8'h00, $past(regs.x)} && !x_inc_valid)
        else $error("x indexed address wrong");
    x_inc_a: assert property (take && req.mode == MODE_DP_X_INC |=>
        x_inc_valid && x_inc_value == 8'($past(regs.x) + 8'h01))
        else $error("x increment wrong");
    dp_off_x_a: assert property (take && req.mode == MODE_DP_OFF_X |=>
        result.ea == {8'h00, 8'($past(req.op_lo) + $past(regs.x))})
        else $error("page plus x wrong");
    dp_off_y_a: assert property (take && req.mode == MODE_DP_OFF_Y |=>
        result.ea == {8'h00, 8'($past(req.op_lo) + $past(regs.y))})
        else $error("page plus y wrong");
    abs_y_a: assert property (take && req.mode == MODE_ABS_Y |=>
        result.ea == {$past(req.op_hi), $past(req.op_lo)} + $past(regs.y))
        else $error("absolute plus y wrong");
    // ----
    // pointer reads
    // ----
    ind_start_a: assert property (take && ind |=> mem_req ##[1:20] done)
        else $error("indirect fetch missing");
    mem_page_a: assert property (mem_req |-> mem_addr[15:8] == 8'h00
        && !req_ready)
        else $error("pointer outside page");
    mem_hold_a: assert property (mem_req && !mem_ack |=> mem_req
        && $stable(mem_addr))
        else $error("pointer read dropped");
    pair_step_a: assert property (mem_req && mem_ack ##1 mem_req |->
        mem_addr[7:0] == 8'($past(mem_addr[7:0]) + 8'h01))
        else $error("pair high byte address wrong");
endmodule
bind operand_address_generator oag_sva u_sva (.mclk(mclk), .rst(rst),
    .req(req), .regs(regs), .req_ready(req_ready), .done(done),
    .result(result), .x_inc_valid(x_inc_valid), .x_inc_value(x_inc_value),
    .mem_req(mem_req), .mem_addr(mem_addr), .mem_rdata(mem_rdata),
    .mem_ack(mem_ack));
`default_nettype wire

// ==== bench/pair_memory_model.sv ====
// page memory answering pointer byte reads after a variable stall
`timescale 1ns/10ps
`default_nettype none
module pair_memory_model (
    input wire logic mclk,
    input wire logic rst,
    input wire logic mem_req,
    input wire logic [15:0] mem_addr,
    input wire logic [1:0] ack_delay,
    output logic [7:0] mem_rdata,
    output logic mem_ack
);
    logic [7:0] mem [256]; // page image, loaded by the bench
    logic [1:0] wait_reg; // stall cycles left
    // data line toggles when idle so a stale byte never looks valid
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            mem_ack <= 1'b0;
            mem_rdata <= 8'hA5;
            wait_reg <= 2'h0;
        end else if (mem_ack) begin
            mem_ack <= 1'b0;
            mem_rdata <= ~mem_rdata;
            wait_reg <= ack_delay;
        end else if (mem_req && wait_reg == 2'h0) begin
            mem_ack <= 1'b1;
            mem_rdata <= mem[mem_addr[7:0]];
        end else if (mem_req) begin
            wait_reg <= wait_reg - 2'h1;
        end else begin
            mem_rdata <= ~mem_rdata;
        end
    end
endmodule
`default_nettype wire

// ==== bench/tb_top.sv ====
// self-checking bench for the operand address generator
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import operand_addr_pkg::*;
    // ----
    // signals
    // ----
    logic mclk = 1'b0;
    logic rst = 1'b1;
    op_req_t req = '0;
    core_regs_t regs = '0;
    logic [1:0] ack_delay = 2'h0; // memory stall per read
    logic req_ready, done, x_inc_valid, mem_req, mem_ack;
    op_result_t result;
    logic [7:0] x_inc_value, mem_rdata;
    logic [15:0] mem_addr;
    logic [31:0] seed = 32'h06064FA6; // fixed for repeatable runs
    int fail_count = 0;
    int samples_checked = 0;
    always #4 mclk = ~mclk;
    operand_address_generator u_dut (.mclk(mclk), .rst(rst), .req(req),
        .regs(regs), .req_ready(req_ready), .done(done), .result(result),
        .x_inc_valid(x_inc_valid), .x_inc_value(x_inc_value),
        .mem_req(mem_req), .mem_addr(mem_addr), .mem_rdata(mem_rdata),
        .mem_ack(mem_ack));
    pair_memory_model u_mem (.mclk(mclk), .rst(rst), .mem_req(mem_req),
        .mem_addr(mem_addr), .ack_delay(ack_delay), .mem_rdata(mem_rdata),
        .mem_ack(mem_ack));
    // ----
    // expectation
    // ----
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // low byte at p, high byte at p+1 wrapping inside the page
    function automatic logic [15:0] pair_at(input logic [7:0] p);
        return {u_mem.mem[8'(p + 8'h01)], u_mem.mem[p]};
    endfunction
    function automatic op_result_t expect_of(input op_req_t r,
                                             input core_regs_t g);
        op_result_t e;
        e = '0;
        e.rmw = r.rmw;
        e.has_addr = 1'b1;
        case (r.mode)
            MODE_REG, MODE_IMM: begin
                e.has_addr = 1'b0;
                e.has_data = 1'b1;
                case (r.mode == MODE_IMM ? 3'h7 : r.reg_sel)
                    3'h0: e.data = g.acc;
                    3'h1: e.data = g.x;
                    3'h2: e.data = g.y;
                    3'h3: e.data = {7'h00, g.carry};
                    3'h4: e.data = g.program_status_word;
                    default: e.data = r.op_lo;
                endcase
            end
            MODE_DP: e.ea = {8'h00, r.op_lo};
            MODE_ABS: e.ea = {r.op_hi, r.op_lo};
            MODE_DP_X, MODE_DP_X_INC: e.ea = {8'h00, g.x};
            MODE_DP_OFF_X: e.ea = {8'h00, 8'(r.op_lo + g.x)};
            MODE_DP_OFF_Y: e.ea = {8'h00, 8'(r.op_lo + g.y)};
            MODE_ABS_Y: e.ea = {r.op_hi, r.op_lo} + {8'h00, g.y};
            MODE_IND_DP: begin
                e.ea = pair_at(r.op_lo);
                e.is_jump = 1'b1;
            end
            MODE_IND_X: e.ea = pair_at(8'(r.op_lo + g.x));
            MODE_IND_Y: e.ea = pair_at(r.op_lo) + {8'h00, g.y};
            default: begin
                e = '0;
                e.rmw = r.rmw; // rmw passes through on every code
            end
        endcase
        return e;
    endfunction
    // ----
    // drivers and compare
    // ----
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one request, then wait for done under a bound
    task automatic run(input addr_mode_t m, input logic [7:0] lo, hi, x, y,
                       input logic rw);
        op_req_t r;
        core_regs_t g;
        op_result_t e;
        int n;
        r = op_req_t'({1'b1, m, rw, 3'(rnd() % 5), lo, hi});
        g = core_regs_t'({8'(rnd()), x, y, 1'(rnd()), 8'(rnd())});
        e = expect_of(r, g);
        @(posedge mclk);
        req <= r;
        regs <= g;
        ack_delay <= 2'(rnd());
        @(posedge mclk);
        req.valid <= 1'b0;
        #1;
        n = 0;
        while (done !== 1'b1 && n < 40) begin
            @(posedge mclk);
            #1;
            n++;
        end
        // a request that never completes counts as a mismatch
        check({15'h0000, done}, 16'h0001);
        check({12'h000, result[3:0]}, {12'h000, e[3:0]});
        if (e.has_addr) check(result.ea, e.ea);
        if (e.has_data) check({8'h00, result.data}, {8'h00, e.data});
        check({15'h0000, x_inc_valid}, {15'h0000, m == MODE_DP_X_INC});
        if (m == MODE_DP_X_INC)
            check({8'h00, x_inc_value}, {8'h00, 8'(x + 8'h01)});
    endtask
    task automatic end_of_test();
        $display("checked %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // ----
    // sequence
    // ----
    initial begin
        for (int i = 0; i < 256; i++) u_mem.mem[i] = 8'(rnd());
        u_mem.mem[8'h25] = 8'hFF;
        u_mem.mem[8'h26] = 8'h12;
        repeat (20) @(posedge mclk);
        rst <= 1'b0;
        // idle after reset: ready, no completion, no pointer read
        #1;
        check({13'h0000, req_ready, done, mem_req}, 16'h0004);
        run(MODE_DP_X_INC, 8'h00, 8'h00, 8'hFF, 8'h00, 1'b0);
        run(MODE_DP_OFF_X, 8'hF0, 8'h00, 8'h20, 8'h00, 1'b0);
        run(MODE_DP_OFF_Y, 8'hFF, 8'h00, 8'h00, 8'h01, 1'b0);
        run(MODE_ABS_Y, 8'hFF, 8'hF0, 8'h00, 8'h10, 1'b0);
        run(MODE_ABS, 8'h35, 8'h00, 8'h00, 8'h00, 1'b1);
        run(MODE_IND_DP, 8'hFF, 8'h00, 8'h00, 8'h00, 1'b0);
        run(MODE_IND_X, 8'h15, 8'h00, 8'h10, 8'h00, 1'b0);
        run(MODE_IND_Y, 8'h25, 8'h00, 8'h00, 8'h10, 1'b0);
        run(addr_mode_t'(4'hF), 8'h12, 8'h34, 8'h00, 8'h00, 1'b1);
        // back to back direct requests, judged by the checker
        @(posedge mclk);
        req <= op_req_t'({1'b1, MODE_DP_X_INC, 1'b0, SEL_ACC, 16'h1234});
        @(posedge mclk);
        req <= op_req_t'({1'b1, MODE_DP_OFF_Y, 1'b0, SEL_ACC, 16'h4567});
        @(posedge mclk);
        req.valid <= 1'b0;
        repeat (300) run(addr_mode_t'(4'(rnd() % 12)), 8'(rnd()), 8'(rnd()),
            8'(rnd()), 8'(rnd()), 1'(rnd()));
        end_of_test();
    end
    // hang guard, far beyond the expected run length
    initial begin
        repeat (30000) @(posedge mclk);
        fail_count++;
        end_of_test();
    end
endmodule
`default_nettype wire
